// [gecr_defs.vh]
// Constants for the gesture engine configuration register bank
`ifndef GECR_DEFS_VH
`define GECR_DEFS_VH

// ****************************************************************
// Register addresses
// ****************************************************************
`define GECR_ADDR_WAIT 8'hA3
`define GECR_ADDR_NORTH 8'hA4
`define GECR_ADDR_SOUTH 8'hA5
`define GECR_ADDR_PULSE 8'hA6
`define GECR_ADDR_WEST 8'hA7
`define GECR_ADDR_EAST 8'hA9

// ****************************************************************
// Field layout and reset values
// ****************************************************************
`define GECR_WAIT_MSB 2
`define GECR_WAIT_LSB 0
`define GECR_WIDTH_MSB 7
`define GECR_WIDTH_LSB 6
`define GECR_COUNT_MSB 5
`define GECR_COUNT_LSB 0
`define GECR_SIGN_BIT 7
`define GECR_MAG_MSB 6
`define GECR_RST_WAIT 3'h0
`define GECR_RST_BYTE 8'h00
`define GECR_READ_NONE 8'h00

// ****************************************************************
// Timing
// ****************************************************************
`define GECR_CLK_MHZ 20
`define GECR_NS_PER_US 1000
`define GECR_WAIT_UNIT_US 2800
`define GECR_PULSE_BASE_NS 4000
`define GECR_LED_EXT_NS 1330
`define GECR_PULSE_GAP_NS 2000
// Wait time in units of the 2.8 ms step, per select code
`define GECR_WAIT_M0 32'd0
`define GECR_WAIT_M1 32'd1
`define GECR_WAIT_M2 32'd2
`define GECR_WAIT_M3 32'd3
`define GECR_WAIT_M4 32'd5
`define GECR_WAIT_M5 32'd8
`define GECR_WAIT_M6 32'd11
`define GECR_WAIT_M7 32'd14

`endif

// [gecr_pulse_gen.v]
// LED pulse train generator for one gesture cycle
`timescale 1ns/10ps
`include "gecr_defs.vh"

module gecr_pulse_gen (
	input wire clk, // System clock
	input wire srst, // Synchronous reset, active high
	input wire start, // Start a pulse train, one-cycle pulse
	input wire abort, // Stop the train at once
	input wire [1:0] width_sel, // LED-on width select
	input wire [5:0] count_m1, // Pulse count minus one
	output reg led_ff, // LED sink active
	output reg integ_ff, // Integration window
	output reg busy_ff, // Train running
	output reg done_ff // Train finished, one-cycle pulse
);

	// ****************************************************************
	// Timing constants
	// ****************************************************************
	localparam [31:0] BASE_FULL = (`GECR_PULSE_BASE_NS * `GECR_CLK_MHZ + `GECR_NS_PER_US - 1)
		/ `GECR_NS_PER_US;
	localparam [31:0] EXT_FULL = (`GECR_LED_EXT_NS * `GECR_CLK_MHZ + `GECR_NS_PER_US - 1)
		/ `GECR_NS_PER_US;
	localparam [31:0] GAP_FULL = (`GECR_PULSE_GAP_NS * `GECR_CLK_MHZ + `GECR_NS_PER_US - 1)
		/ `GECR_NS_PER_US;
	// Counts fit the 11-bit phase counter; cut on purpose
	localparam [10:0] BASE_CYC = BASE_FULL[10:0];
	localparam [10:0] EXT_CYC = EXT_FULL[10:0];
	localparam [10:0] GAP_CYC = GAP_FULL[10:0];
	localparam ST_IDLE = 2'h0;
	localparam ST_ON = 2'h1;
	localparam ST_GAP = 2'h2;

	// ****************************************************************
	// State
	// ****************************************************************
	reg [1:0] state_ff;
	reg [1:0] nxt_state;
	reg [10:0] cnt_ff;
	reg [10:0] nxt_cnt;
	reg [5:0] left_ff;
	reg [5:0] nxt_left;
	reg [10:0] width_ff;
	reg [10:0] nxt_width;
	reg nxt_led;
	reg nxt_integ;
	reg nxt_done;

	// Next state: on phase of width plus extension, then gap
	always @* begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_left = left_ff;
		nxt_width = width_ff;
		nxt_done = 1'b0;
		case (state_ff)
			ST_IDLE: begin
				if (start && !abort) begin
					nxt_width = BASE_CYC << width_sel;
					nxt_left = count_m1;
					nxt_cnt = 11'h000;
					nxt_state = ST_ON;
				end
			end
			ST_ON: begin
				if (cnt_ff == width_ff + EXT_CYC - 11'h001) begin
					nxt_cnt = 11'h000;
					nxt_state = ST_GAP;
				end else begin
					nxt_cnt = cnt_ff + 11'h001;
				end
			end
			ST_GAP: begin
				if (cnt_ff == GAP_CYC - 11'h001) begin
					nxt_cnt = 11'h000;
					if (left_ff == 6'h00) begin
						nxt_state = ST_IDLE;
						nxt_done = 1'b1;
					end else begin
						nxt_left = left_ff - 6'h01;
						nxt_state = ST_ON;
					end
				end else begin
					nxt_cnt = cnt_ff + 11'h001;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
		if (abort) begin
			nxt_state = ST_IDLE;
			nxt_done = 1'b0;
		end
		nxt_led = (nxt_state == ST_ON);
		nxt_integ = (nxt_state == ST_ON) && (nxt_cnt < nxt_width);
	end

	// State registers
	always @(posedge clk) begin
		if (srst) begin
			state_ff <= ST_IDLE;
			cnt_ff <= 11'h000;
			left_ff <= 6'h00;
			width_ff <= 11'h000;
			led_ff <= 1'b0;
			integ_ff <= 1'b0;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			left_ff <= nxt_left;
			width_ff <= nxt_width;
			led_ff <= nxt_led;
			integ_ff <= nxt_integ;
			busy_ff <= (nxt_state != ST_IDLE);
			done_ff <= nxt_done;
		end
	end

endmodule // gecr_pulse_gen

// [gecr_config_regs.v]
// Gesture engine configuration registers with cycle sequencer
//
// Contract
// - Between cycles the engine idles in low power for 0, 2.8, 5.6, 8.4, 14, 22.4, 30.8 or 39.2 ms.
// - The pulse width is the integration time and the LED stays on about 1.33 us longer.
// - Each offset byte is sign and magnitude, bit 7 sign and bits 6:0 magnitude, -127 to +127.
// - North, south, west and east each hold their own 8-bit offset correction value.
// - Bits 7:6 of the pulse register select an LED-on width of 4, 8, 16 or 32 us.
// - Each cycle drives the pulse count field of bits 5:0 plus one pulses on the LED sink pin.
`timescale 1ns/10ps
`include "gecr_defs.vh"

module gecr_config_regs #(
	parameter WAIT_UNIT_CYC = `GECR_WAIT_UNIT_US * `GECR_CLK_MHZ // Cycles per 2.8 ms step
) (
	input wire clk, // System clock, 20 MHz
	input wire srst, // Synchronous reset, active high
	input wire [7:0] reg_addr, // Register address
	input wire [7:0] reg_wdata, // Write data
	input wire reg_wr, // Write strobe, one cycle
	input wire reg_rd, // Read strobe, one cycle
	output reg [7:0] reg_rdata_ff, // Read data, valid the cycle after reg_rd
	input wire gesture_engine_enable, // Engine enable from control logic
	output wire led_sink_pin, // LED sink current on, active high
	output wire integrate, // Integration window, active high
	output reg low_power_ff, // Waiting between cycles
	output reg cycle_done_ff, // Gesture cycle finished, one-cycle pulse
	output reg [8:0] north_offset_factor_ff, // North correction, two's complement
	output reg [8:0] south_offset_factor_ff, // South correction, two's complement
	output reg [8:0] west_offset_factor_ff, // West correction, two's complement
	output reg [8:0] east_offset_factor_ff // East correction, two's complement
);

	// ****************************************************************
	// Local definitions
	// ****************************************************************
	localparam ST_IDLE = 2'h0;
	localparam ST_PULSE = 2'h1;
	localparam ST_WAIT = 2'h2;

	// Sign/magnitude byte to two's complement; negative zero maps to zero
	function [8:0] sm_to_tc;
		input [7:0] v;
		reg [8:0] mag;
		begin
			mag = {2'b00, v[`GECR_MAG_MSB:0]};
			if (v[`GECR_SIGN_BIT]) begin
				sm_to_tc = 9'h000 - mag;
			end else begin
				sm_to_tc = mag;
			end
		end
	endfunction

	// Wait select code to a cycle count
	function [19:0] wait_cycles;
		input [2:0] sel;
		reg [31:0] mult;
		reg [31:0] prod;
		begin
			mult = `GECR_WAIT_M0;
			case (sel)
				3'h1: mult = `GECR_WAIT_M1;
				3'h2: mult = `GECR_WAIT_M2;
				3'h3: mult = `GECR_WAIT_M3;
				3'h4: mult = `GECR_WAIT_M4;
				3'h5: mult = `GECR_WAIT_M5;
				3'h6: mult = `GECR_WAIT_M6;
				3'h7: mult = `GECR_WAIT_M7;
				default: mult = `GECR_WAIT_M0;
			endcase
			prod = mult * WAIT_UNIT_CYC;
			wait_cycles = prod[19:0];
		end
	endfunction

	// ****************************************************************
	// Register file
	// ****************************************************************
	reg [2:0] wait_sel_ff;
	reg [7:0] north_offset_value_ff;
	reg [7:0] south_offset_value_ff;
	reg [7:0] west_offset_value_ff;
	reg [7:0] east_offset_value_ff;
	reg [7:0] pulse_cfg_ff;

	// Register writes, decoded by address
	always @(posedge clk) begin
		if (srst) begin
			wait_sel_ff <= `GECR_RST_WAIT;
			north_offset_value_ff <= `GECR_RST_BYTE;
			south_offset_value_ff <= `GECR_RST_BYTE;
			west_offset_value_ff <= `GECR_RST_BYTE;
			east_offset_value_ff <= `GECR_RST_BYTE;
			pulse_cfg_ff <= `GECR_RST_BYTE;
		end else if (reg_wr) begin
			if (reg_addr == `GECR_ADDR_WAIT) begin
				wait_sel_ff <= reg_wdata[`GECR_WAIT_MSB:`GECR_WAIT_LSB];
			end else if (reg_addr == `GECR_ADDR_NORTH) begin
				north_offset_value_ff <= reg_wdata;
			end else if (reg_addr == `GECR_ADDR_SOUTH) begin
				south_offset_value_ff <= reg_wdata;
			end else if (reg_addr == `GECR_ADDR_PULSE) begin
				pulse_cfg_ff <= reg_wdata;
			end else if (reg_addr == `GECR_ADDR_WEST) begin
				west_offset_value_ff <= reg_wdata;
			end else if (reg_addr == `GECR_ADDR_EAST) begin
				east_offset_value_ff <= reg_wdata;
			end
		end
	end

	// Read data, captured on the read strobe; unmapped addresses read zero
	always @(posedge clk) begin
		if (srst) begin
			reg_rdata_ff <= `GECR_READ_NONE;
		end else if (reg_rd) begin
			if (reg_addr == `GECR_ADDR_WAIT) begin
				reg_rdata_ff <= {5'h00, wait_sel_ff};
			end else if (reg_addr == `GECR_ADDR_NORTH) begin
				reg_rdata_ff <= north_offset_value_ff;
			end else if (reg_addr == `GECR_ADDR_SOUTH) begin
				reg_rdata_ff <= south_offset_value_ff;
			end else if (reg_addr == `GECR_ADDR_PULSE) begin
				reg_rdata_ff <= pulse_cfg_ff;
			end else if (reg_addr == `GECR_ADDR_WEST) begin
				reg_rdata_ff <= west_offset_value_ff;
			end else if (reg_addr == `GECR_ADDR_EAST) begin
				reg_rdata_ff <= east_offset_value_ff;
			end else begin
				reg_rdata_ff <= `GECR_READ_NONE;
			end
		end
	end

	// ****************************************************************
	// Offset correction factors
	// ****************************************************************

	// Per-channel signed factors for the correction datapath
	always @(posedge clk) begin
		if (srst) begin
			north_offset_factor_ff <= 9'h000;
			south_offset_factor_ff <= 9'h000;
			west_offset_factor_ff <= 9'h000;
			east_offset_factor_ff <= 9'h000;
		end else begin
			north_offset_factor_ff <= sm_to_tc(north_offset_value_ff);
			south_offset_factor_ff <= sm_to_tc(south_offset_value_ff);
			west_offset_factor_ff <= sm_to_tc(west_offset_value_ff);
			east_offset_factor_ff <= sm_to_tc(east_offset_value_ff);
		end
	end

	// ****************************************************************
	// Cycle sequencer
	// ****************************************************************
	reg [1:0] state_ff;
	reg [1:0] nxt_state;
	reg [19:0] wait_cnt_ff;
	reg [19:0] nxt_wait_cnt;
	reg start_ff;
	reg nxt_start;
	reg [7:0] snap_pulse_ff;
	reg [2:0] snap_wait_ff;
	wire pg_done;

	// Pulse phase, then low-power wait, repeated while enabled
	always @* begin
		nxt_state = state_ff;
		nxt_wait_cnt = wait_cnt_ff;
		nxt_start = 1'b0;
		case (state_ff)
			ST_IDLE: begin
				if (gesture_engine_enable) begin
					nxt_start = 1'b1;
					nxt_state = ST_PULSE;
				end
			end
			ST_PULSE: begin
				if (pg_done) begin
					nxt_wait_cnt = wait_cycles(snap_wait_ff);
					if (wait_cycles(snap_wait_ff) == 20'h00000) begin
						nxt_start = 1'b1;
					end else begin
						nxt_state = ST_WAIT;
					end
				end
			end
			ST_WAIT: begin
				if (wait_cnt_ff == 20'h00001) begin
					nxt_wait_cnt = 20'h00000;
					nxt_start = 1'b1;
					nxt_state = ST_PULSE;
				end else begin
					nxt_wait_cnt = wait_cnt_ff - 20'h00001;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
		if (!gesture_engine_enable) begin
			nxt_state = ST_IDLE;
			nxt_start = 1'b0;
			nxt_wait_cnt = 20'h00000;
		end
	end

	// Sequencer registers; settings are sampled as each cycle starts
	always @(posedge clk) begin
		if (srst) begin
			state_ff <= ST_IDLE;
			wait_cnt_ff <= 20'h00000;
			start_ff <= 1'b0;
			snap_pulse_ff <= `GECR_RST_BYTE;
			snap_wait_ff <= `GECR_RST_WAIT;
			low_power_ff <= 1'b0;
			cycle_done_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			wait_cnt_ff <= nxt_wait_cnt;
			start_ff <= nxt_start;
			if (nxt_start) begin
				snap_pulse_ff <= pulse_cfg_ff;
				snap_wait_ff <= wait_sel_ff;
			end
			low_power_ff <= (nxt_state == ST_WAIT);
			cycle_done_ff <= pg_done && gesture_engine_enable;
		end
	end

	// LED pulse train
	gecr_pulse_gen u_pulse (
		.clk(clk),
		.srst(srst),
		.start(start_ff),
		.abort(!gesture_engine_enable),
		.width_sel(snap_pulse_ff[`GECR_WIDTH_MSB:`GECR_WIDTH_LSB]),
		.count_m1(snap_pulse_ff[`GECR_COUNT_MSB:`GECR_COUNT_LSB]),
		.led_ff(led_sink_pin),
		.integ_ff(integrate),
		.busy_ff(),
		.done_ff(pg_done)
	);

endmodule // gecr_config_regs

// [gecr_config_regs_asserts.sv]
// Port assertions for the gesture engine configuration registers
`timescale 1ns/10ps
`include "gecr_defs.vh"
module gecr_chk (
	input wire clk, // Clock
	input wire srst, // Reset
	input wire [7:0] reg_addr, // Address
	input wire [7:0] reg_wdata, // Write data
	input wire reg_wr, // Write strobe
	input wire reg_rd, // Read strobe
	input wire [7:0] reg_rdata_ff, // Read data
	input wire gesture_engine_enable, // Enable
	input wire led_sink_pin, // LED sink
	input wire integrate, // Integration window
	input wire low_power_ff, // Wait state
	input wire cycle_done_ff, // Train done
	input wire [8:0] north_offset_factor_ff, // North factor
	input wire [8:0] south_offset_factor_ff, // South factor
	input wire [8:0] west_offset_factor_ff, // West factor
	input wire [8:0] east_offset_factor_ff // East factor
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	// Sign and magnitude byte to two's complement
	function automatic [8:0] sm(input [7:0] v);
		sm = v[7] ? 9'h000 - {2'h0, v[6:0]} : {2'h0, v[6:0]};
	endfunction
	// ****************
	// Properties
	// ****************
	led_integ_a: assert property ($rose(led_sink_pin) |-> integrate)
		else $error("integration window does not open with the LED");
	led_ext_a: assert property ($fell(integrate) && gesture_engine_enable |->
		##26 (led_sink_pin || !gesture_engine_enable) ##1 !led_sink_pin)
		else $error("LED extension after integration is wrong");
	led_gap_a: assert property ($fell(led_sink_pin) |-> !led_sink_pin [*8])
		else $error("LED pulses too close together");
	abort_dark_a: assert property (!gesture_engine_enable |=>
		!led_sink_pin && !integrate && !low_power_ff)
		else $error("engine active while disabled");
	start_lat_a: assert property ($rose(gesture_engine_enable) |-> ##2 led_sink_pin)
		else $error("first pulse late after enable");
	north_fac_a: assert property (reg_wr && reg_addr == `GECR_ADDR_NORTH |->
		##2 north_offset_factor_ff == sm($past(reg_wdata, 2)))
		else $error("north factor wrong");
	east_fac_a: assert property (reg_wr && reg_addr == `GECR_ADDR_EAST |->
		##2 east_offset_factor_ff == sm($past(reg_wdata, 2)))
		else $error("east factor wrong");
	rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata_ff))
		else $error("read data moved without a read");
	unmapped_read_a: assert property (reg_rd && reg_addr == 8'hA8 |=> reg_rdata_ff == 8'h00)
		else $error("unmapped read not empty");
	done_pulse_a: assert property (cycle_done_ff |=> !cycle_done_ff)
		else $error("done flag longer than one cycle");
endmodule // gecr_chk

bind gecr_config_regs gecr_chk i_chk (.clk(clk), .srst(srst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
	.gesture_engine_enable(gesture_engine_enable), .led_sink_pin(led_sink_pin),
	.integrate(integrate), .low_power_ff(low_power_ff), .cycle_done_ff(cycle_done_ff),
	.north_offset_factor_ff(north_offset_factor_ff),
	.south_offset_factor_ff(south_offset_factor_ff),
	.west_offset_factor_ff(west_offset_factor_ff),
	.east_offset_factor_ff(east_offset_factor_ff));

// [gecr_host.sv]
// Host controller model for the register strobes and engine enable
`timescale 1ns/10ps
module gecr_host (
	input wire clk, // Clock
	output reg [7:0] reg_addr, // Address
	output reg [7:0] reg_wdata, // Write data
	output reg reg_wr, // Write strobe
	output reg reg_rd, // Read strobe
	output reg gesture_engine_enable, // Enable
	input wire [7:0] reg_rdata_ff // Read data
);
	// Idle bus at time zero
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		gesture_engine_enable = 1'b0;
	end
	// One write; released lines show the inverse so stale data never matches
	task wr(input [7:0] a, input [7:0] d);
		begin
			@(posedge clk);
			reg_addr <= a;
			reg_wdata <= d;
			reg_wr <= 1'b1;
			@(posedge clk);
			reg_wr <= 1'b0;
			reg_addr <= ~a;
			reg_wdata <= ~d;
		end
	endtask
	// One read; data is taken once it has settled
	task rd(input [7:0] a, output [7:0] d);
		begin
			@(posedge clk);
			reg_addr <= a;
			reg_rd <= 1'b1;
			@(posedge clk);
			reg_rd <= 1'b0;
			reg_addr <= ~a;
			@(posedge clk);
			#1;
			d = reg_rdata_ff;
		end
	endtask
	// Change the engine enable
	task en(input v);
		begin
			@(posedge clk);
			gesture_engine_enable <= v;
		end
	endtask
endmodule // gecr_host

// [gecr_config_regs_tb.sv]
// Self-checking testbench of the gesture engine configuration registers
`timescale 1ns/10ps
`include "gecr_defs.vh"
module gecr_config_regs_tb;
	localparam UNIT = 10;
	localparam [39:0] MULT = {5'd14, 5'd11, 5'd8, 5'd5, 5'd3, 5'd2, 5'd1, 5'd0};
	reg clk;
	reg srst;
	wire [7:0] reg_addr, reg_wdata, reg_rdata_ff;
	wire reg_wr, reg_rd, gesture_engine_enable, led_sink_pin, integrate, low_power_ff, done;
	wire [8:0] fac_n, fac_s, fac_w, fac_e;
	reg [7:0] d;
	integer err_total, checks;
	// ****************
	// Design and host
	// ****************
	gecr_config_regs #(.WAIT_UNIT_CYC(UNIT)) i_dut (.clk(clk), .srst(srst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
		.gesture_engine_enable(gesture_engine_enable), .led_sink_pin(led_sink_pin),
		.integrate(integrate), .low_power_ff(low_power_ff), .cycle_done_ff(done),
		.north_offset_factor_ff(fac_n), .south_offset_factor_ff(fac_s),
		.west_offset_factor_ff(fac_w), .east_offset_factor_ff(fac_e));
	gecr_host i_host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .gesture_engine_enable(gesture_engine_enable),
		.reg_rdata_ff(reg_rdata_ff));
	// Compare a design value
	task chk_val(input [95:0] nm, input [8:0] exp, input [8:0] got);
		begin
			checks = checks + 1;
			if (got !== exp) begin
				err_total = err_total + 1;
				$display("wrong value %0s expected %h seen %h", nm, exp, got);
			end
		end
	endtask
	// Compare a cycle count
	task chk_cnt(input [95:0] nm, input integer exp, input integer got);
		begin
			checks = checks + 1;
			if (got !== exp) begin
				err_total = err_total + 1;
				$display("wrong value %0s expected %0d seen %0d", nm, exp, got);
			end
		end
	endtask
	// Verdict and end of run
	task end_of_test;
		begin
			$display("comparisons %0d mismatches %0d", checks, err_total);
			if (err_total == 0 && checks > 0) begin
				$display("NO MISMATCHES");
			end else begin
				$display("MISMATCHES SEEN");
			end
			$finish;
		end
	endtask
	// Read back, offset factors, unmapped place, narrow wait register
	task t_regs;
		begin
			i_host.wr(`GECR_ADDR_NORTH, 8'h82);
			i_host.wr(`GECR_ADDR_SOUTH, 8'h7F);
			i_host.wr(`GECR_ADDR_WEST, 8'hFF);
			i_host.wr(`GECR_ADDR_EAST, 8'h01);
			i_host.wr(`GECR_ADDR_PULSE, 8'hC5);
			i_host.wr(`GECR_ADDR_WAIT, 8'hFE);
			i_host.wr(8'hA8, 8'h5A);
			i_host.rd(`GECR_ADDR_NORTH, d);
			chk_val("north", 9'h082, {1'b0, d});
			i_host.rd(`GECR_ADDR_PULSE, d);
			chk_val("pulse", 9'h0C5, {1'b0, d});
			i_host.rd(`GECR_ADDR_WAIT, d);
			chk_val("wait", 9'h006, {1'b0, d});
			i_host.rd(8'hA8, d);
			chk_val("unmapped", 9'h000, {1'b0, d});
			chk_val("north fac", 9'h1FE, fac_n);
			chk_val("south fac", 9'h07F, fac_s);
			chk_val("west fac", 9'h181, fac_w);
			chk_val("east fac", 9'h001, fac_e);
			i_host.wr(`GECR_ADDR_NORTH, 8'h80);
			i_host.rd(`GECR_ADDR_WEST, d);
			chk_val("west", 9'h0FF, {1'b0, d});
			chk_val("neg zero", 9'h000, fac_n);
		end
	endtask
	// One train: pulse count, LED and integration cycles
	task t_train(input [1:0] ws, input [5:0] cnt);
		integer i, nled, nint, np, w;
		reg prev;
		begin
			w = 80 << ws;
			i_host.wr(`GECR_ADDR_WAIT, 8'h00);
			i_host.wr(`GECR_ADDR_PULSE, {ws, cnt});
			i_host.en(1'b1);
			nled = 0;
			nint = 0;
			np = 0;
			prev = 1'b0;
			i = 0;
			do begin
				@(posedge clk);
				#1;
				i = i + 1;
				if (led_sink_pin === 1'b1) nled = nled + 1;
				if (integrate === 1'b1) nint = nint + 1;
				if (led_sink_pin === 1'b1 && !prev) np = np + 1;
				prev = led_sink_pin;
			end while (done !== 1'b1 && i < 50000);
			i_host.en(1'b0);
			repeat (60) @(posedge clk);
			chk_cnt("pulses", cnt + 1, np);
			chk_cnt("integ cyc", w * (cnt + 1), nint);
			chk_cnt("led cyc", (w + 27) * (cnt + 1), nled);
		end
	endtask
	// Low-power wait length for every select code
	task t_wait;
		integer c, i, n;
		begin
			i_host.wr(`GECR_ADDR_PULSE, 8'h00);
			for (c = 0; c < 8; c = c + 1) begin
				i_host.wr(`GECR_ADDR_WAIT, c[7:0]);
				i_host.en(1'b1);
				n = 0;
				i = 0;
				do begin
					@(posedge clk);
					#1;
					i = i + 1;
				end while (done !== 1'b1 && i < 500);
				while (led_sink_pin !== 1'b1 && i < 800) begin
					if (low_power_ff === 1'b1) n = n + 1;
					@(posedge clk);
					#1;
					i = i + 1;
				end
				chk_cnt("wait cyc", MULT[c * 5 +: 5] * UNIT, n);
				i_host.en(1'b0);
				repeat (20) @(posedge clk);
			end
		end
	endtask
	// Enable dropped in mid-pulse
	task t_abort;
		begin
			i_host.wr(`GECR_ADDR_PULSE, 8'hC3);
			i_host.en(1'b1);
			repeat (30) @(posedge clk);
			i_host.en(1'b0);
			repeat (2) @(posedge clk);
			#1;
			chk_val("abort led", 9'h000, {8'h00, led_sink_pin});
			chk_val("abort int", 9'h000, {8'h00, integrate});
		end
	endtask
	// Reset in mid-run clears the east register and its factor
	task t_reset;
		begin
			i_host.wr(`GECR_ADDR_EAST, 8'h85);
			@(posedge clk);
			srst <= 1'b1;
			repeat (3) @(posedge clk);
			srst <= 1'b0;
			i_host.rd(`GECR_ADDR_EAST, d);
			chk_val("rst east", 9'h000, {1'b0, d});
			chk_val("rst fac", 9'h000, fac_e);
		end
	endtask
	// Clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// Cut a hang short
	initial begin
		#5000000;
		err_total = err_total + 1;
		end_of_test;
	end
	// Main sequence
	initial begin
		srst = 1'b1;
		err_total = 0;
		checks = 0;
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		t_regs;
		t_train(2'h0, 6'h00);
		t_train(2'h1, 6'h02);
		t_train(2'h2, 6'h01);
		t_train(2'h3, 6'h3F);
		t_wait;
		t_abort;
		t_reset;
		end_of_test;
	end
endmodule // gecr_config_regs_tb
